// ### core/tarl_top.sv
// Three 16-bit auto-reload timers behind a byte register port.
// Assumes a processor-side master with one-cycle strobes and an
// interrupt controller that acknowledges each timer request.
//
// Summary of operation
// - timer A clock: 00 system, 10 low-speed
// - timer A counts only while run set
// - timer A reads show count or reload
// - timer C reads show count or reload
// - timer B writes reload, reads count
// - timer B wraps, reloads counter, flags in reload mode only
// - timer B high write loads counter
// - timer B mode: 00 reload, 01 baud
// - timer B reload-mode overflow requests interrupt
// - run set never clears the count
// - baud mode reloads without interrupt
// - baud rate is overflow rate over 32
// - timer B prescale 1, 8, 64, 256
// - timer B source bit must be 0
// - timer B flag set and cleared by hardware
// - timer C wraps, flags, reloads counter
// - timer C high write loads counter
// - timer C overflow requests interrupt when enabled
// - timer C runs on control bit 1
// - timer C prescale 1, 8, 64, 256
// - timer A wraps, flags, reloads counter
// - timer A prescale 1, 8, 64, 256
`timescale 1ns/1ps
module tarl_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Low-speed clock pin
  input wire logic lsclk_pin_i,
  // Interrupt controller side
  input wire logic timer_a_irq_enable_i,
  input wire logic timer_b_irq_enable_i,
  input wire logic timer_c_irq_enable_i,
  input wire logic timer_a_irq_ack_i,
  input wire logic timer_b_irq_ack_i,
  input wire logic timer_c_irq_ack_i,
  output logic timer_a_irq_o,
  output logic timer_b_irq_o,
  output logic timer_c_irq_o,
  // Serial port side
  output logic baud_tick_o
);
  import tarl_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Strobe aimed at one register address
  function automatic logic tarl_hit(input logic stb, input logic [7:0] addr,
                                    input logic [7:0] target);
    return stb && (addr == target);
  endfunction : tarl_hit

  // Byte update of a 16-bit reload register
  function automatic logic [15:0] tarl_reload_upd(input logic [15:0] cur,
      input logic wr_lo, input logic wr_hi, input logic [7:0] data);
    logic [15:0] v;
    v = cur;
    if (wr_lo)
      v[7:0] = data;
    if (wr_hi)
      v[15:8] = data;
    return v;
  endfunction : tarl_reload_upd

  // Overflow flag next value: a hardware set always wins
  function automatic logic tarl_flag_next(input logic cur, input logic set,
      input logic ack, input logic wr, input logic wbit);
    if (set)
      return 1'b1;
    else if (ack)
      return 1'b0;
    else if (wr)
      return wbit;
    else
      return cur;
  endfunction : tarl_flag_next

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] a_ctrl_r; // Timer A control, flag excluded
  logic [7:0] b_ctrl_r; // Timer B control, flag excluded
  logic [7:0] c_ctrl_r; // Timer C control, flag excluded
  logic [7:0] rb_sel_r; // Readback selector
  logic [15:0] a_reload_r; // Reload registers
  logic [15:0] b_reload_r;
  logic [15:0] c_reload_r;
  logic a_flag_r; // Overflow flags
  logic b_flag_r;
  logic c_flag_r;
  logic [2:0] lsclk_s_r; // Pin synchroniser chain
  logic lsclk_lvl_r; // Accepted pin level
  logic lsclk_rise; // One-cycle low-speed tick
  logic [7:0] rdata_r; // Read data register
  logic [7:0] rd_mux; // Read decode
  logic a_irq_r; // Request outputs
  logic b_irq_r;
  logic c_irq_r;
  logic baud_r; // Serial tick output
  logic a_run; // Decoded fields
  logic b_run;
  logic c_run;
  logic [1:0] a_clks;
  logic [1:0] b_mode;
  logic a_tick; // Count enables per timer
  logic b_tick;
  logic c_tick;
  logic a_load; // High-byte writes
  logic b_load;
  logic c_load;
  logic [15:0] a_reload_in; // Reload values seen by the timers
  logic [15:0] b_reload_in;
  logic [15:0] c_reload_in;
  logic [15:0] a_count; // Live counts
  logic [15:0] b_count;
  logic [15:0] c_count;
  logic [15:0] a_view; // Readback views
  logic [15:0] c_view;
  logic a_ovf; // Overflow pulses
  logic b_ovf;
  logic c_ovf;

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  assign a_run = a_ctrl_r[TARL_A_RUN_BIT];
  assign b_run = b_ctrl_r[TARL_B_RUN_BIT];
  assign c_run = c_ctrl_r[TARL_C_RUN_BIT];
  assign a_clks = a_ctrl_r[TARL_A_CLK_LSB +: 2];
  assign b_mode = b_ctrl_r[TARL_B_MODE_LSB +: 2];

  // Reserved clock codes leave timer A frozen
  assign a_tick = (a_clks == TARL_A_CLK_SYS) ? 1'b1 :
                  (a_clks == TARL_A_CLK_LOW) ? lsclk_rise : 1'b0;
  // Reserved source or mode stops timer B
  assign b_tick = (b_ctrl_r[TARL_B_CLK_BIT] == TARL_B_CLK_SYS) &&
                  ((b_mode == TARL_B_MODE_RELOAD) ||
                   (b_mode == TARL_B_MODE_BAUD));
  assign c_tick = 1'b1;

  assign a_load = tarl_hit(reg_wr_i, reg_addr_i, TARL_A_HI);
  assign b_load = tarl_hit(reg_wr_i, reg_addr_i, TARL_B_HI);
  assign c_load = tarl_hit(reg_wr_i, reg_addr_i, TARL_C_HI);

  // High write pairs new high byte with the low byte written earlier
  assign a_reload_in = a_load ? {reg_wdata_i, a_reload_r[7:0]} : a_reload_r;
  assign b_reload_in = b_load ? {reg_wdata_i, b_reload_r[7:0]} : b_reload_r;
  assign c_reload_in = c_load ? {reg_wdata_i, c_reload_r[7:0]} : c_reload_r;

  // Readback selector picks count or reload for timers A and C
  assign a_view = rb_sel_r[TARL_RB_A_BIT] ? a_reload_r : a_count;
  assign c_view = rb_sel_r[TARL_RB_C_BIT] ? c_reload_r : c_count;

  // ------------------------------------------------------------
  // Low-speed clock pin
  // ------------------------------------------------------------

  // Three-stage chain; only stages two and three are compared
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lsclk_s_r <= 3'h0;
    else
      lsclk_s_r <= {lsclk_s_r[1:0], lsclk_pin_i};
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lsclk_lvl_r <= 1'b0;
    else if (lsclk_s_r[1] == lsclk_s_r[2])
      lsclk_lvl_r <= lsclk_s_r[2];
  end

  assign lsclk_rise = (lsclk_s_r[1] == lsclk_s_r[2]) && lsclk_s_r[2] && !lsclk_lvl_r;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------

  // Control bytes; unused bits stay zero through the masks
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_ctrl_r <= TARL_RST_BYTE;
      b_ctrl_r <= TARL_RST_BYTE;
      c_ctrl_r <= TARL_RST_BYTE;
      rb_sel_r <= TARL_RST_BYTE;
    end
    else
    begin
      if (tarl_hit(reg_wr_i, reg_addr_i, TARL_A_CTRL))
        a_ctrl_r <= reg_wdata_i & TARL_A_MASK;
      if (tarl_hit(reg_wr_i, reg_addr_i, TARL_B_CTRL))
        b_ctrl_r <= reg_wdata_i & TARL_B_MASK;
      if (tarl_hit(reg_wr_i, reg_addr_i, TARL_C_CTRL))
        c_ctrl_r <= reg_wdata_i & TARL_C_MASK;
      if (tarl_hit(reg_wr_i, reg_addr_i, TARL_RB_SEL))
        rb_sel_r <= reg_wdata_i & TARL_RB_MASK;
    end
  end

  // Reload registers take data writes; counters read back live
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_reload_r <= TARL_RST_WORD;
      b_reload_r <= TARL_RST_WORD;
      c_reload_r <= TARL_RST_WORD;
    end
    else
    begin
      a_reload_r <= tarl_reload_upd(a_reload_r,
        tarl_hit(reg_wr_i, reg_addr_i, TARL_A_LO), a_load, reg_wdata_i);
      b_reload_r <= tarl_reload_upd(b_reload_r,
        tarl_hit(reg_wr_i, reg_addr_i, TARL_B_LO), b_load, reg_wdata_i);
      c_reload_r <= tarl_reload_upd(c_reload_r,
        tarl_hit(reg_wr_i, reg_addr_i, TARL_C_LO), c_load, reg_wdata_i);
    end
  end

  // ------------------------------------------------------------
  // Timer channels
  // ------------------------------------------------------------

  // Run bit gates counting; setting it leaves the count alone
  tarl_timer16 #(.WIDTH(16)) u_timer_a (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(a_run),
    .tick_i(a_tick),
    .prescale_i(a_ctrl_r[TARL_PS_LSB +: 2]),
    .load_i(a_load),
    .reload_i(a_reload_in),
    .count_o(a_count),
    .ovf_o(a_ovf)
  );

  tarl_timer16 #(.WIDTH(16)) u_timer_b (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(b_run),
    .tick_i(b_tick),
    .prescale_i(b_ctrl_r[TARL_PS_LSB +: 2]),
    .load_i(b_load),
    .reload_i(b_reload_in),
    .count_o(b_count),
    .ovf_o(b_ovf)
  );

  tarl_timer16 #(.WIDTH(16)) u_timer_c (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(c_run),
    .tick_i(c_tick),
    .prescale_i(c_ctrl_r[TARL_PS_LSB +: 2]),
    .load_i(c_load),
    .reload_i(c_reload_in),
    .count_o(c_count),
    .ovf_o(c_ovf)
  );

  // ------------------------------------------------------------
  // Overflow flags
  // ------------------------------------------------------------

  // Set by overflow, cleared by the controller's acknowledge;
  // software may also write the bit, but never beats a set
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_flag_r <= 1'b0;
      b_flag_r <= 1'b0;
      c_flag_r <= 1'b0;
    end
    else
    begin
      a_flag_r <= tarl_flag_next(a_flag_r, a_ovf, timer_a_irq_ack_i,
        tarl_hit(reg_wr_i, reg_addr_i, TARL_A_CTRL), reg_wdata_i[TARL_FLAG_BIT]);
      // Baud mode overflows never touch the flag
      b_flag_r <= tarl_flag_next(b_flag_r, b_ovf && (b_mode == TARL_B_MODE_RELOAD),
        timer_b_irq_ack_i, tarl_hit(reg_wr_i, reg_addr_i, TARL_B_CTRL),
        reg_wdata_i[TARL_FLAG_BIT]);
      c_flag_r <= tarl_flag_next(c_flag_r, c_ovf, timer_c_irq_ack_i,
        tarl_hit(reg_wr_i, reg_addr_i, TARL_C_CTRL), reg_wdata_i[TARL_FLAG_BIT]);
    end
  end

  // ------------------------------------------------------------
  // Requests and serial tick
  // ------------------------------------------------------------

  // Registered requests: one cycle behind the flag, by design
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_irq_r <= 1'b0;
      b_irq_r <= 1'b0;
      c_irq_r <= 1'b0;
    end
    else
    begin
      a_irq_r <= a_flag_r && timer_a_irq_enable_i;
      b_irq_r <= b_flag_r && timer_b_irq_enable_i &&
                 (b_mode == TARL_B_MODE_RELOAD);
      c_irq_r <= c_flag_r && timer_c_irq_enable_i;
    end
  end

  // Serial port divides this tick by 32 to form the bit rate
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      baud_r <= 1'b0;
    else
      baud_r <= b_ovf && (b_mode == TARL_B_MODE_BAUD);
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  // Read decode; unmapped addresses read zero. Data reads are not
  // latched, so software must stop the timer and read high first.
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      TARL_A_CTRL: rd_mux = {a_flag_r, a_ctrl_r[6:0]};
      TARL_RB_SEL: rd_mux = rb_sel_r;
      TARL_A_LO: rd_mux = a_view[7:0];
      TARL_A_HI: rd_mux = a_view[15:8];
      TARL_C_CTRL: rd_mux = {c_flag_r, c_ctrl_r[6:0]};
      TARL_B_CTRL: rd_mux = {b_flag_r, b_ctrl_r[6:0]};
      TARL_B_LO: rd_mux = b_count[7:0];
      TARL_B_HI: rd_mux = b_count[15:8];
      TARL_C_LO: rd_mux = c_view[7:0];
      TARL_C_HI: rd_mux = c_view[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_r <= 8'h00;
    else if (reg_rd_i)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata_o = rdata_r;
  assign timer_a_irq_o = a_irq_r;
  assign timer_b_irq_o = b_irq_r;
  assign timer_c_irq_o = c_irq_r;
  assign baud_tick_o = baud_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_b_baud_ovf;
    b_ovf && (b_mode == TARL_B_MODE_BAUD) && !b_flag_r && !reg_wr_i;
  endsequence

  sequence s_c_ovf_en;
    c_ovf ##1 timer_c_irq_enable_i;
  endsequence

  AST_A_RESERVED_CLK: assert property ((a_clks != TARL_A_CLK_SYS &&
      a_clks != TARL_A_CLK_LOW && !a_load) |=> a_count == $past(a_count))
    else $error("timer A counted on a reserved clock");
  AST_A_READ_RELOAD: assert property ((tarl_hit(reg_rd_i, reg_addr_i, TARL_A_HI) &&
      rb_sel_r[TARL_RB_A_BIT]) |=> reg_rdata_o == $past(a_reload_r[15:8]))
    else $error("timer A reload readback wrong");
  AST_A_READ_COUNT: assert property ((tarl_hit(reg_rd_i, reg_addr_i, TARL_A_LO) &&
      !rb_sel_r[TARL_RB_A_BIT]) |=> reg_rdata_o == $past(a_count[7:0]))
    else $error("timer A count readback wrong");
  AST_C_READ_RELOAD: assert property ((tarl_hit(reg_rd_i, reg_addr_i, TARL_C_LO) &&
      rb_sel_r[TARL_RB_C_BIT]) |=> reg_rdata_o == $past(c_reload_r[7:0]))
    else $error("timer C reload readback wrong");
  AST_B_READ_COUNT: assert property (tarl_hit(reg_rd_i, reg_addr_i, TARL_B_HI)
      |=> reg_rdata_o == $past(b_count[15:8]))
    else $error("timer B read did not show count");
  AST_RD_IDLE_ZERO: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  AST_B_HI_LOAD: assert property (b_load
      |=> b_count == {$past(reg_wdata_i), $past(b_reload_r[7:0])})
    else $error("timer B high write did not load");
  AST_C_HI_LOAD: assert property (c_load
      |=> c_count == {$past(reg_wdata_i), $past(c_reload_r[7:0])})
    else $error("timer C high write did not load");
  AST_B_FLAG_SET: assert property ((b_ovf && b_mode == TARL_B_MODE_RELOAD)
      |=> b_flag_r)
    else $error("timer B flag lost on overflow");
  AST_B_BAUD_NOIRQ: assert property (s_b_baud_ovf |=> !b_flag_r ##1 !timer_b_irq_o)
    else $error("baud overflow raised a request");
  AST_B_BAUD_TICK: assert property ((b_ovf && b_mode == TARL_B_MODE_BAUD)
      |=> baud_tick_o)
    else $error("baud tick missing");
  AST_C_IRQ: assert property (s_c_ovf_en |=> timer_c_irq_o)
    else $error("timer C request missing");
endmodule : tarl_top

// ### core/tarl_pkg.sv
// Constants shared by the triple auto-reload timer block.
// Assumes a byte-wide register port with 8-bit addresses.
package tarl_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] TARL_A_CTRL = 8'h88;
  localparam logic [7:0] TARL_RB_SEL = 8'h89;
  localparam logic [7:0] TARL_A_LO = 8'h8c;
  localparam logic [7:0] TARL_A_HI = 8'h8d;
  localparam logic [7:0] TARL_C_CTRL = 8'hc0;
  localparam logic [7:0] TARL_B_CTRL = 8'hc8;
  localparam logic [7:0] TARL_B_LO = 8'hcc;
  localparam logic [7:0] TARL_B_HI = 8'hcd;
  localparam logic [7:0] TARL_C_LO = 8'hce;
  localparam logic [7:0] TARL_C_HI = 8'hcf;
  // ------------------------------------------------------------
  // Field positions and writable masks (flag bit kept apart)
  // ------------------------------------------------------------
  localparam int TARL_FLAG_BIT = 7;
  localparam int TARL_PS_LSB = 4;
  localparam int TARL_A_RUN_BIT = 2;
  localparam int TARL_A_CLK_LSB = 0;
  localparam int TARL_B_MODE_LSB = 2;
  localparam int TARL_B_RUN_BIT = 1;
  localparam int TARL_B_CLK_BIT = 0;
  localparam int TARL_C_RUN_BIT = 1;
  localparam int TARL_RB_A_BIT = 0;
  localparam int TARL_RB_C_BIT = 1;
  localparam logic [7:0] TARL_A_MASK = 8'h37;
  localparam logic [7:0] TARL_B_MASK = 8'h3f;
  localparam logic [7:0] TARL_C_MASK = 8'h32;
  localparam logic [7:0] TARL_RB_MASK = 8'h03;
  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] TARL_RST_BYTE = 8'h00;
  localparam logic [15:0] TARL_RST_WORD = 16'h0000;
  localparam logic [1:0] TARL_A_CLK_SYS = 2'b00;
  localparam logic [1:0] TARL_A_CLK_LOW = 2'b10;
  localparam logic [1:0] TARL_B_MODE_RELOAD = 2'b00;
  localparam logic [1:0] TARL_B_MODE_BAUD = 2'b01;
  localparam logic TARL_B_CLK_SYS = 1'b0;
  // Prescaler terminal counts for divide by 1, 8, 64, 256
  localparam logic [7:0] TARL_PS_LIM_1 = 8'h00;
  localparam logic [7:0] TARL_PS_LIM_8 = 8'h07;
  localparam logic [7:0] TARL_PS_LIM_64 = 8'h3f;
  localparam logic [7:0] TARL_PS_LIM_256 = 8'hff;

  // Terminal count of the prescaler for a two-bit code
  function automatic logic [7:0] tarl_ps_limit(input logic [1:0] code);
    case (code)
      2'b00: return TARL_PS_LIM_1;
      2'b01: return TARL_PS_LIM_8;
      2'b10: return TARL_PS_LIM_64;
      default: return TARL_PS_LIM_256;
    endcase
  endfunction : tarl_ps_limit
endpackage : tarl_pkg

// ### core/tarl_timer16.sv
// One up-counting auto-reload timer channel with prescaler.
// Assumes the parent holds the reload register and decodes loads.
`timescale 1ns/1ps
module tarl_timer16 #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Count control
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [1:0] prescale_i,
  // Reload path
  input wire logic load_i,
  input wire logic [WIDTH-1:0] reload_i,
  // State
  output logic [WIDTH-1:0] count_o,
  output logic ovf_o
);
  import tarl_pkg::*;

  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};

  logic [7:0] ps_cnt_r; // Prescaler position
  logic [7:0] ps_lim; // Terminal count of prescaler
  logic step; // One counter increment this cycle
  logic [WIDTH-1:0] cnt_r; // Live count
  logic ovf_r; // Overflow pulse

  assign ps_lim = tarl_ps_limit(prescale_i);
  // Code change mid-period is caught by the compare, not equality
  assign step = run_i && tick_i && (ps_cnt_r >= ps_lim);
  assign count_o = cnt_r;
  assign ovf_o = ovf_r;

  // Prescaler: holds while stopped so a restart resumes the period
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ps_cnt_r <= 8'h00;
    else if (run_i && tick_i)
    begin
      if (step)
        ps_cnt_r <= 8'h00;
      else
        ps_cnt_r <= ps_cnt_r + 8'h01;
    end
  end

  // Counter: a load beats both reload and increment
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_r <= {WIDTH{1'b0}};
    else if (load_i)
      cnt_r <= reload_i;
    else if (step)
    begin
      if (cnt_r == CNT_MAX)
        cnt_r <= reload_i; // Wrap reloads
      else
        cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Overflow pulse, one cycle, aligned with the reloaded count
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ovf_r <= 1'b0;
    else
      ovf_r <= step && !load_i && (cnt_r == CNT_MAX);
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_div8_run;
    (run_i && tick_i && prescale_i == 2'b01 && !load_i) [*8];
  endsequence

  AST_T_HOLD: assert property ((!run_i && !load_i) |=> cnt_r == $past(cnt_r))
    else $error("count moved while stopped");
  AST_T_WRAP: assert property ((step && !load_i && cnt_r == CNT_MAX)
      |=> ovf_r && cnt_r == $past(reload_i))
    else $error("wrap did not reload or flag");
  AST_T_LOAD: assert property (load_i |=> cnt_r == $past(reload_i))
    else $error("load did not copy reload");
  AST_T_DIV8: assert property ((step && prescale_i == 2'b01) ##1 s_div8_run |-> step)
    else $error("divide by eight period wrong");
endmodule : tarl_timer16

// ### dv/tarl_irq_host.sv
// Interrupt controller model facing the three timer requests.
// Assumes requests are levels that drop two cycles after the ack.
`timescale 1ns/1ps
module tarl_irq_host (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Requests in, acks out
  input wire logic [2:0] irq_i,
  output logic [2:0] ack_o
);
  // One-cycle ack per request; skipping a cycle keeps acks apart, so a held level is acked every other cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_o <= 3'h0;
    else
      ack_o <= irq_i & ~ack_o;
  end
endmodule : tarl_irq_host

// ### dv/testbench.sv
// Self-checking bench for the triple auto-reload timer block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module testbench;
  import tarl_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lsclk = 1'b0;
  logic [2:0] en = 3'h0;
  logic [7:0] rdata;
  logic [2:0] ack;
  logic [2:0] irq;
  logic baud;
  int fails = 0;
  int checked = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  tarl_top u_tarl_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lsclk_pin_i(lsclk), .timer_a_irq_enable_i(en[0]), .timer_b_irq_enable_i(en[1]),
    .timer_c_irq_enable_i(en[2]), .timer_a_irq_ack_i(ack[0]), .timer_b_irq_ack_i(ack[1]),
    .timer_c_irq_ack_i(ack[2]), .timer_a_irq_o(irq[0]), .timer_b_irq_o(irq[1]),
    .timer_c_irq_o(irq[2]), .baud_tick_o(baud));
  tarl_irq_host u_tarl_irq_host (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .irq_i(irq),
    .ack_o(ack));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe, so look there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  // Bounded wait for a request or tick bit; n returns cycles waited
  task automatic wait_ev(input int b, output int n);
    logic [3:0] ev;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1 n++;
      ev = {baud, irq};
    end while (ev[b] !== 1'b1 && n < 3000);
  endtask : wait_ev
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] ra [4] = '{TARL_A_CTRL, TARL_B_CTRL, TARL_C_CTRL, TARL_RB_SEL};
    logic [7:0] rm [4] = '{8'hb7, 8'hbf, 8'hb2, 8'h03};
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(ra[i], 8'h00);
      wr_reg(ra[i], 8'hff);
      rd_chk(ra[i], rm[i]);
      wr_reg(ra[i], 8'h00);
    end
    wr_reg(8'h00, 8'hff);
    rd_chk(8'h00, 8'h00);
  endtask : t_regs
  task automatic t_readback;
    logic [7:0] lo [3] = '{TARL_A_LO, TARL_B_LO, TARL_C_LO};
    logic [7:0] sel [3] = '{8'h01, 8'h00, 8'h02};
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(lo[i], 8'h34);
      wr_reg(lo[i] + 8'h01, 8'h12);
      wr_reg(lo[i], 8'h56);
      rd_chk(lo[i] + 8'h01, 8'h12);
      rd_chk(lo[i], 8'h34);
      if (sel[i] != 8'h00)
      begin
        wr_reg(TARL_RB_SEL, sel[i]);
        rd_chk(lo[i], 8'h56);
        wr_reg(TARL_RB_SEL, 8'h00);
      end
    end
  endtask : t_readback
  // Overflow sets flag; request waits for enable, ack clears the flag
  task automatic t_overflow;
    logic [7:0] ca [3] = '{TARL_A_CTRL, TARL_B_CTRL, TARL_C_CTRL};
    logic [7:0] rn [3] = '{8'h04, 8'h02, 8'h02};
    logic [7:0] lo [3] = '{TARL_A_LO, TARL_B_LO, TARL_C_LO};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(lo[i], 8'hfe);
      wr_reg(lo[i] + 8'h01, 8'hff);
      wr_reg(ca[i], rn[i]);
      repeat (10) @(posedge clk_sys_i);
      rd_chk(ca[i], rn[i] | 8'h80);
      wr_reg(ca[i], 8'h80);
      en[i] <= 1'b1;
      #1 chk(irq[i], 1'b0);
      // Flag already up, so the registered request follows one edge later
      wait_ev(i, n);
      chk(16'(n), 16'h0001);
      repeat (4) @(posedge clk_sys_i);
      rd_chk(ca[i], 8'h00);
      en[i] <= 1'b0;
    end
    // Timer C overflowing while its request is enabled
    @(posedge clk_sys_i);
    en[2] <= 1'b1;
    wr_reg(TARL_C_CTRL, 8'h02);
    wait_ev(2, n);
    chk(16'(n < 8), 16'h0001);
    wr_reg(TARL_C_CTRL, 8'h00);
    repeat (8) @(posedge clk_sys_i);
    rd_chk(TARL_C_CTRL, 8'h00);
    chk(irq[2], 1'b0);
    @(posedge clk_sys_i);
    en[2] <= 1'b0;
  endtask : t_overflow
  // Pin clock drives timer A; a stopped timer ignores further edges
  task automatic t_lowclk;
    wr_reg(TARL_A_LO, 8'h00);
    wr_reg(TARL_A_HI, 8'h00);
    wr_reg(TARL_A_CTRL, 8'h06);
    // Pin level toggles every four system cycles: five rising edges
    repeat (10)
    begin
      repeat (4) @(posedge clk_sys_i);
      lsclk <= ~lsclk;
    end
    repeat (8) @(posedge clk_sys_i);
    wr_reg(TARL_A_CTRL, 8'h02);
    repeat (4)
    begin
      repeat (4) @(posedge clk_sys_i);
      lsclk <= ~lsclk;
    end
    repeat (8) @(posedge clk_sys_i);
    rd_chk(TARL_A_LO, 8'h05);
  endtask : t_lowclk
  // Tick spacing is two counts of the prescaled clock; no request
  task automatic t_baud;
    int dv [4] = '{1, 8, 64, 256};
    int n;
    en[1] <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(TARL_B_LO, 8'hfe);
      wr_reg(TARL_B_HI, 8'hff);
      wr_reg(TARL_B_CTRL, 8'(p << 4) | 8'h06);
      wait_ev(3, n);
      wait_ev(3, n);
      chk(16'(n), 16'(2 * dv[p]));
      chk(irq[1], 1'b0);
      rd_chk(TARL_B_CTRL, 8'(p << 4) | 8'h06);
      wr_reg(TARL_B_CTRL, 8'h00);
    end
    en[1] <= 1'b0;
  endtask : t_baud
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Watchdog: the tests need well under 10k cycles
  initial
  begin
    #500000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_readback();
    t_overflow();
    t_lowclk();
    t_baud();
    finish_test();
  end
endmodule : testbench
